//--- rtl/rer_error_records.sv
// two error records, fault interrupts and pseudo-fault injection
`timescale 1ns/10ps
`default_nettype none
`include "rer_defines.svh"
// Behaviour
// - every detected protected-RAM error is logged in a software-visible record
// - two records; select register chooses which one the selected views show
// - record zero is this core's, fed by L1, TLB and L2 errors
// - record one logs L3 and snoop filter errors, shared by the cluster
// - interrupt index zero for shared errors, index n+1 for core n
// - single-bit ECC on L1 data access is a corrected error
// - double-bit on L1 eviction or snoop is a postponed error
// - double-bit on L1 tag after eviction is uncontainable
// - double-bit on L1 data read is a restartable error
// - block injects errors into its own detection logic
// - read-only feature register lists injectable error types
// - control register selects which error types are injected
// - countdown register sets when the injected fault takes effect
// - injection never alters stored RAM contents
// - uncorrectable tag or dirty error invalidates line and interrupts
module rer_error_records
   import rer_pkg::*;
#(
   parameter int CORE_INDEX = 0,
   parameter int NUM_CORES = 1,
   parameter int CDN_WIDTH = `RER_CDN_WIDTH
)(
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire rer_report_t coreReport,
   input wire rer_report_t sharedReport,
   input wire logic recordSelectWrite,
   input wire logic recordSelectData,
   input wire logic statusClear,
   input wire logic injControlWrite,
   input wire rer_pfg_t injControlData,
   input wire logic injCountdownWrite,
   input wire logic [CDN_WIDTH-1:0] injCountdownData,
   output logic record_select_reg,
   output rer_status_t selected_record_status_reg,
   output logic [3:0] selected_injection_feature_reg,
   output rer_pfg_t selected_injection_control_reg,
   output logic [CDN_WIDTH-1:0] selected_injection_countdown_reg,
   output logic [3:0] injection_feature_reg,
   output logic invalidateLine,
   output logic [NUM_CORES:0] fault_interrupt_out_low
);
   rer_status_t rec0_q;
   rer_status_t rec1_q;
   logic selReg_q;
   rer_pfg_t pfg_q;
   logic [CDN_WIDTH-1:0] cdn_q;
   logic fire;
   rer_sev_t injSev;
   rer_sev_t coreSev;
   rer_sev_t sharedSev;
   logic coreEvent;
   logic sharedEvent;
   logic invalidate_q;
   logic [NUM_CORES:0] irqLow_q;
   rer_status_t statusView_q;
   logic [3:0] selFeatView_q;
   logic [3:0] featReg_q;
   rer_pfg_t ctlView_q;
   logic [CDN_WIDTH-1:0] cdnView_q;

   function automatic rer_sev_t classify(input rer_report_t r);
      rer_sev_t s;
      s = ERR_NONE;
      if (r.valid)
      begin
         if (r.eccBits == 2'h1)
            s = ERR_CORRECTED;
         else if (r.srcKind == SRC_L1_EVICT || r.srcKind == SRC_L1_SNOOP)
            s = ERR_POSTPONED;
         else if (r.srcKind == SRC_L1_TAG || r.srcKind == SRC_DIRTY)
            s = ERR_UNCONTAINABLE;
         else if (r.srcKind == SRC_L1D_READ)
            s = ERR_RESTARTABLE;
         else
            s = ERR_UNCONTAINABLE;
      end
      return s;
   endfunction : classify

   // injected fault: highest enabled type, fed to record zero and the core fault line
   always_comb
   begin
      fire = pfg_q.armed && (cdn_q == '0);
      injSev = ERR_NONE;
      if (fire)
      begin
         if (pfg_q.typeEn[2])
            injSev = ERR_UNCONTAINABLE;
         else if (pfg_q.typeEn[3])
            injSev = ERR_RESTARTABLE;
         else if (pfg_q.typeEn[1])
            injSev = ERR_POSTPONED;
         else if (pfg_q.typeEn[0])
            injSev = ERR_CORRECTED;
      end
   end

   always_comb
   begin
      coreSev = classify(coreReport);
      if (injSev > coreSev)
         coreSev = injSev;
      sharedSev = classify(sharedReport);
      coreEvent = coreSev != ERR_NONE;
      sharedEvent = sharedSev != ERR_NONE;
   end

   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         selReg_q <= `RER_REC_CORE;
      else if (recordSelectWrite)
         selReg_q <= recordSelectData;
   end

   // record zero, core private; set beats clear
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         rec0_q <= '{valid: 1'b0, overflow: 1'b0, sev: ERR_NONE};
      else if (coreEvent)
      begin
         rec0_q.valid <= 1'b1;
         rec0_q.overflow <= rec0_q.valid && !(statusClear && selReg_q == `RER_REC_CORE);
         if (coreSev > rec0_q.sev || (statusClear && selReg_q == `RER_REC_CORE))
            rec0_q.sev <= coreSev;
      end
      else if (statusClear && selReg_q == `RER_REC_CORE)
         rec0_q <= '{valid: 1'b0, overflow: 1'b0, sev: ERR_NONE};
   end

   // record one, shared by the cluster
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         rec1_q <= '{valid: 1'b0, overflow: 1'b0, sev: ERR_NONE};
      else if (sharedEvent)
      begin
         rec1_q.valid <= 1'b1;
         rec1_q.overflow <= rec1_q.valid && !(statusClear && selReg_q == `RER_REC_SHARED);
         if (sharedSev > rec1_q.sev || (statusClear && selReg_q == `RER_REC_SHARED))
            rec1_q.sev <= sharedSev;
      end
      else if (statusClear && selReg_q == `RER_REC_SHARED)
         rec1_q <= '{valid: 1'b0, overflow: 1'b0, sev: ERR_NONE};
   end

   // injection control and countdown
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         pfg_q <= '{armed: 1'b0, typeEn: `RER_CTL_RESET};
         cdn_q <= '0;
      end
      else
      begin
         if (injControlWrite)
            pfg_q <= '{armed: injControlData.armed, typeEn: injControlData.typeEn & `RER_PFG_FEAT};
         else if (fire)
            pfg_q.armed <= 1'b0;
         if (injCountdownWrite)
            cdn_q <= injCountdownData;
         else if (pfg_q.armed && cdn_q != '0)
            cdn_q <= cdn_q - 1'b1;
      end
   end

   // line invalidate on tag or dirty uncorrectable
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         invalidate_q <= 1'b0;
      else
         invalidate_q <= coreReport.valid && coreReport.eccBits == 2'h2
            && (coreReport.srcKind == SRC_L1_TAG || coreReport.srcKind == SRC_DIRTY);
   end

   // active-low fault lines, held while the record is valid
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
         irqLow_q <= '1;
      else
      begin
         irqLow_q <= '1;
         irqLow_q[0] <= !(rec1_q.valid || sharedEvent);
         irqLow_q[CORE_INDEX+1] <= !(rec0_q.valid || coreEvent);
      end
   end

   // software views, registered; they trail the record state by one cycle
   always_ff @(posedge ref_clk or negedge reset_n)
   begin
      if (!reset_n)
      begin
         statusView_q <= '{valid: 1'b0, overflow: 1'b0, sev: ERR_NONE};
         selFeatView_q <= `RER_PFG_FEAT;
         featReg_q <= `RER_PFG_FEAT;
         ctlView_q <= '{armed: 1'b0, typeEn: `RER_CTL_RESET};
         cdnView_q <= '0;
      end
      else
      begin
         statusView_q <= selReg_q ? rec1_q : rec0_q;
         selFeatView_q <= selReg_q ? 4'h0 : `RER_PFG_FEAT;
         featReg_q <= `RER_PFG_FEAT;
         ctlView_q <= selReg_q ? rer_pfg_t'('0) : pfg_q;
         cdnView_q <= selReg_q ? '0 : cdn_q;
      end
   end

   always_comb
   begin
      record_select_reg = selReg_q;
      selected_record_status_reg = statusView_q;
      selected_injection_feature_reg = selFeatView_q;
      selected_injection_control_reg = ctlView_q;
      selected_injection_countdown_reg = cdnView_q;
      injection_feature_reg = featReg_q;
      invalidateLine = invalidate_q;
      fault_interrupt_out_low = irqLow_q;
   end

   // a core report landing on an empty record with no injected fault on top
   sequence s_fresh_core;
      coreReport.valid && !rec0_q.valid && !fire;
   endsequence

   // an injected fault carrying at least one enabled type
   sequence s_injected;
      fire && pfg_q.typeEn != 4'h0;
   endsequence

   property p_irq_held;
      @(posedge ref_clk) disable iff (!reset_n)
      rec0_q.valid |=> !fault_interrupt_out_low[CORE_INDEX+1];
   endproperty
   a_irq_held: assert property (p_irq_held)
      else $error("core fault line not asserted");

   property p_shared_line;
      @(posedge ref_clk) disable iff (!reset_n)
      sharedReport.valid |=> !fault_interrupt_out_low[0];
   endproperty
   a_shared_line: assert property (p_shared_line)
      else $error("shared fault line not asserted");

   property p_core_record;
      @(posedge ref_clk) disable iff (!reset_n)
      coreReport.valid |=> rec0_q.valid;
   endproperty
   a_core_record: assert property (p_core_record)
      else $error("core error not logged in record zero");

   property p_shared_record;
      @(posedge ref_clk) disable iff (!reset_n)
      sharedReport.valid |=> rec1_q.valid;
   endproperty
   a_shared_record: assert property (p_shared_record)
      else $error("shared error not logged in record one");

   property p_corrected;
      @(posedge ref_clk) disable iff (!reset_n)
      s_fresh_core ##0 (coreReport.eccBits == 2'h1) |=> rec0_q.sev == ERR_CORRECTED;
   endproperty
   a_corrected: assert property (p_corrected)
      else $error("single-bit error not recorded as corrected");

   property p_postponed;
      @(posedge ref_clk) disable iff (!reset_n)
      s_fresh_core ##0 (coreReport.eccBits == 2'h2
         && (coreReport.srcKind == SRC_L1_EVICT || coreReport.srcKind == SRC_L1_SNOOP))
      |=> rec0_q.sev == ERR_POSTPONED;
   endproperty
   a_postponed: assert property (p_postponed)
      else $error("eviction or snoop error not recorded as postponed");

   property p_uncontainable;
      @(posedge ref_clk) disable iff (!reset_n)
      coreReport.valid && coreReport.eccBits == 2'h2 && coreReport.srcKind == SRC_L1_TAG
      |=> rec0_q.sev == ERR_UNCONTAINABLE;
   endproperty
   a_uncontainable: assert property (p_uncontainable)
      else $error("tag error not recorded as uncontainable");

   property p_restartable;
      @(posedge ref_clk) disable iff (!reset_n)
      s_fresh_core ##0 (coreReport.eccBits == 2'h2 && coreReport.srcKind == SRC_L1D_READ)
      |=> rec0_q.sev == ERR_RESTARTABLE;
   endproperty
   a_restartable: assert property (p_restartable)
      else $error("data read error not recorded as restartable");

   property p_inject;
      @(posedge ref_clk) disable iff (!reset_n)
      s_injected |=> rec0_q.valid;
   endproperty
   a_inject: assert property (p_inject)
      else $error("injected fault not logged");

   property p_countdown;
      @(posedge ref_clk) disable iff (!reset_n)
      pfg_q.armed && cdn_q != '0 && !injCountdownWrite |=> cdn_q == $past(cdn_q) - 1'b1;
   endproperty
   a_countdown: assert property (p_countdown)
      else $error("injection countdown did not step");

   property p_invalidate;
      @(posedge ref_clk) disable iff (!reset_n)
      coreReport.valid && coreReport.eccBits == 2'h2
         && (coreReport.srcKind == SRC_L1_TAG || coreReport.srcKind == SRC_DIRTY)
      |=> invalidateLine;
   endproperty
   a_invalidate: assert property (p_invalidate)
      else $error("line not invalidated on tag or dirty error");
endmodule : rer_error_records
`default_nettype wire

//--- rtl/rer_defines.svh
// offsets-free constants for the error record and injection block
`ifndef RER_DEFINES_SVH
`define RER_DEFINES_SVH
`define RER_REC_CORE 1'h0
`define RER_REC_SHARED 1'h1
`define RER_PFG_FEAT 4'hF
`define RER_CTL_RESET 4'h0
`define RER_CDN_WIDTH 32
`define RER_IRQ_IDLE 1'h1
`endif

//--- rtl/rer_pkg.sv
// types for the error record and injection block
`default_nettype none
package rer_pkg;
   typedef enum logic [2:0] {ERR_NONE, ERR_CORRECTED, ERR_POSTPONED, ERR_RESTARTABLE, ERR_UNCONTAINABLE} rer_sev_t;
   // one error report from a protected RAM
   typedef struct packed {
      logic valid;
      logic [2:0] srcKind;
      logic [1:0] eccBits;
   } rer_report_t;
   // status view of one record
   typedef struct packed {
      logic valid;
      logic overflow;
      rer_sev_t sev;
   } rer_status_t;
   // injection controls: enables for corrected, postponed, uncontainable, restartable
   typedef struct packed {
      logic armed;
      logic [3:0] typeEn;
   } rer_pfg_t;
   localparam logic [2:0] SRC_L1D_ACCESS = 3'h0;
   localparam logic [2:0] SRC_L1_EVICT = 3'h1;
   localparam logic [2:0] SRC_L1_SNOOP = 3'h2;
   localparam logic [2:0] SRC_L1_TAG = 3'h3;
   localparam logic [2:0] SRC_L1D_READ = 3'h4;
   localparam logic [2:0] SRC_DIRTY = 3'h5;
   localparam logic [2:0] SRC_OTHER = 3'h6;
endpackage : rer_pkg
`default_nettype wire

//--- testbench/tb.sv
// self-checking bench for the error record and injection block
`timescale 1ns/10ps
`default_nettype none
`define CMP(a, b) compare(a, b)
module tb;
   import rer_pkg::*;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   rer_report_t coreReport = '0;
   rer_report_t sharedReport = '0;
   logic recordSelectWrite = 1'b0;
   logic recordSelectData = 1'b0;
   logic statusClear = 1'b0;
   logic injControlWrite = 1'b0;
   rer_pfg_t injControlData = '0;
   logic injCountdownWrite = 1'b0;
   logic [7:0] injCountdownData = 8'h00;
   logic record_select_reg;
   rer_status_t selected_record_status_reg;
   logic [3:0] selected_injection_feature_reg;
   rer_pfg_t selected_injection_control_reg;
   logic [7:0] selected_injection_countdown_reg;
   logic [3:0] injection_feature_reg;
   logic invalidateLine;
   logic [1:0] fault_interrupt_out_low;
   logic [1:0] invCnt = 2'h0;
   logic [30:0] expQ[$];
   logic [1:0] eIrq, eInv;
   logic [4:0] eSt, eCtl;
   logic eSel;
   logic [7:0] eCdn;
   logic [15:0] rng = 16'h3C20;
   int num_errors = 0;
   int cmp_count = 0;
   int i;
   always #12.5 ref_clk = ~ref_clk;
   rer_error_records #(.CORE_INDEX(0), .NUM_CORES(1), .CDN_WIDTH(8)) rer_error_records_inst (.ref_clk, .reset_n,
      .coreReport, .sharedReport, .recordSelectWrite, .recordSelectData, .statusClear, .injControlWrite,
      .injControlData, .injCountdownWrite, .injCountdownData, .record_select_reg, .selected_record_status_reg,
      .selected_injection_feature_reg, .selected_injection_control_reg, .selected_injection_countdown_reg,
      .injection_feature_reg, .invalidateLine, .fault_interrupt_out_low);
   always @(posedge ref_clk) if (invalidateLine === 1'b1) invCnt <= invCnt + 2'h1;
   // watcher: compares the output snapshot with every queued note, oldest first, until the queue is empty
   always @(negedge ref_clk)
   begin
      #2;
      while (expQ.size() > 0) `CMP({fault_interrupt_out_low, selected_record_status_reg, record_select_reg,
         selected_injection_feature_reg, injection_feature_reg, selected_injection_control_reg,
         selected_injection_countdown_reg, invCnt}, expQ.pop_front());
   end
   task compare(input logic [30:0] a, input logic [30:0] b);
      cmp_count++;
      if (a !== b)
      begin
         num_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, a, b);
      end
   endtask : compare
   task complete_run();
      if (num_errors == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : complete_run
   task note();
      expQ.push_back({eIrq, eSt, eSel, eSel ? 4'h0 : 4'hF, 4'hF, eSel ? 5'h00 : eCtl, eSel ? 8'h00 : eCdn, eInv});
   endtask : note
   task cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : cyc
   task rep(input logic sh, input logic [2:0] k, input logic [1:0] e);
      if (sh) sharedReport = {1'b1, k, e};
      else coreReport = {1'b1, k, e};
      cyc(1);
      sharedReport.valid = 1'b0;
      coreReport.valid = 1'b0;
   endtask : rep
   task wsel(input logic b);
      recordSelectData = b;
      recordSelectWrite = 1'b1;
      cyc(1);
      recordSelectWrite = 1'b0;
      eSel = b;
      cyc(1);
   endtask : wsel
   task clr();
      statusClear = 1'b1;
      cyc(1);
      statusClear = 1'b0;
      cyc(1);
      eSt = 5'h00;
      eIrq = 2'h3;
      note();
   endtask : clr
   task inj(input logic [4:0] c, input logic [7:0] d);
      injControlData = c;
      injCountdownData = d;
      injControlWrite = 1'b1;
      injCountdownWrite = 1'b1;
      cyc(1);
      injControlWrite = 1'b0;
      injCountdownWrite = 1'b0;
   endtask : inj
   initial
   begin
      {eIrq, eSt, eSel, eCtl, eCdn, eInv} = {2'h3, 5'h00, 1'b0, 5'h00, 8'h00, 2'h0};
      cyc(3);
      reset_n = 1'b1;
      cyc(1);
      note();
      rep(1'b0, SRC_L1D_ACCESS, 2'h1);
      cyc(1);
      {eIrq, eSt} = {2'h1, 2'b10, ERR_CORRECTED};
      note();
      clr();
      for (i = 0; i < 3; i++)
      begin
         rep(1'b0, i == 0 ? SRC_L1_EVICT : i == 1 ? SRC_L1_SNOOP : SRC_L1D_READ, 2'h2);
         cyc(1);
         {eIrq, eSt} = {2'h1, 2'b10, i < 2 ? ERR_POSTPONED : ERR_RESTARTABLE};
         note();
         clr();
      end
      rep(1'b0, SRC_L1D_ACCESS, 2'h1);
      cyc(1);
      rep(1'b0, SRC_L1_TAG, 2'h2);
      cyc(2);
      {eIrq, eSt, eInv} = {2'h1, 2'b11, ERR_UNCONTAINABLE, 2'h1};
      note();
      clr();
      rep(1'b1, SRC_OTHER, 2'h1);
      cyc(1);
      eIrq = 2'h2;
      note();
      wsel(1'b1);
      eSt = {2'b10, ERR_CORRECTED};
      note();
      clr();
      wsel(1'b0);
      rng = rng ^ (rng << 7);
      rng = rng ^ (rng >> 9);
      rng = rng ^ (rng << 8);
      inj({1'b0, rng[3:0]}, rng[11:4] | 8'h01);
      {eCtl, eCdn} = {1'b0, rng[3:0], rng[11:4] | 8'h01};
      cyc(1);
      note();
      inj(5'h11, 8'h05);
      for (i = 0; i < 300 && selected_record_status_reg.valid !== 1'b1; i++) cyc(1);
      if (i == 300)
         num_errors++;
      else
      begin
         cyc(1);
         {eIrq, eSt, eCtl, eCdn} = {2'h1, 2'b10, ERR_CORRECTED, 5'h01, 8'h00};
         note();
         clr();
      end
      cyc(2);
      complete_run();
   end
endmodule : tb
`default_nettype wire
